/* File: core/adc_output_frame_composer.sv */
// Output frame composer: control registers on APB, frame assembly on
// ref_clk and the serial shifter on the host's serial clock.
// Assumes conversion data, alarm flags and the unit id come from logic
// on ref_clk; the host holds frameSelectN low at least 4 ref_clk cycles
// before its first serial clock edge.
`timescale 1ns/1ps

module adc_output_frame_composer
    import frame_composer_pkg::*;
#(
    parameter int DATA_W = CONV_BITS
)(
    // Clocks and resets
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     appResetReq,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [APB_ADDR_BITS-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Frame contents from the converter side
    input  wire logic [DATA_W-1:0]        convData,
    input  wire logic                     convValid,
    input  wire logic [UNIT_ID_BITS-1:0]  unitId,
    input  wire logic                     supplyAlarmHigh,
    input  wire logic                     supplyAlarmLow,
    input  wire logic                     inputAlarmHigh,
    input  wire logic                     inputAlarmLow,
    // Analogue controls
    output logic                          onchipRefOff,
    output logic      [SPAN_BITS-1:0]     spanCode,
    output logic                          spanCodeLegal,
    // Serial link
    input  wire logic                     serialClk,
    input  wire logic                     frameSelectN,
    output logic                          serialOutLines
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int MAX_W = DATA_W + UNIT_ID_BITS + 4 + SPAN_BITS
                         + PARITY_BITS;
    localparam int LEN_W = $clog2(MAX_W + 1);

    typedef struct packed {
        logic                    csMeta;
        logic                    csSync;
        logic [DATA_W-1:0]       convLatch;
        logic                    includeUnitId;
        logic [1:0]              supplyAlarmInsertSel;
        logic [1:0]              inputAlarmInsertSel;
        logic                    includeSpanCode;
        logic                    parityAppendOn;
        logic [2:0]              dataPatternSel;
        logic                    refOff;
        logic [SPAN_BITS-1:0]    span;
        logic                    spanLegal;
        logic [MAX_W-1:0]        txWord;
        logic [LEN_W-1:0]        txLen;
        logic                    ready;
        logic                    slvErr;
        logic [31:0]             rdata;
    } ref_state_type;

    typedef struct packed {
        logic [LEN_W-1:0]        bitIdx;
        logic                    serialOut;
    } link_state_type;

    typedef struct packed {
        logic [MAX_W-1:0]        word;
        logic [LEN_W-1:0]        len;
    } frame_type;

    ref_state_type  r;
    ref_state_type  next_r;
    link_state_type l;
    link_state_type next_l;

    logic [DATA_W-1:0] altSingle;
    logic [DATA_W-1:0] altPair;

    // ------------------------------------------------------------------
    // Test patterns, MSB first
    // ------------------------------------------------------------------
    // alternating pattern bits
    for (genvar i = 0; i < DATA_W; i++)
    begin : g_pattern
        localparam int POS = DATA_W - 1 - i;
        assign altSingle[i] = (POS % 2) == 1;
        assign altPair[i]   = ((POS / 2) % 2) == 1;
    end

    function automatic logic span_legal(input logic [SPAN_BITS-1:0] c);
        logic ok;
        ok = 1'b0;
        unique case (c)
            SPAN_BI_3_00, SPAN_BI_2_50, SPAN_BI_1_50, SPAN_BI_1_25,
            SPAN_BI_0_625, SPAN_UNI_3_00, SPAN_UNI_2_50, SPAN_UNI_1_50,
            SPAN_UNI_1_25: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic [1:0] sel_flags(input logic [1:0] sel,
                                             input logic       hi,
                                             input logic       lo);
        logic [1:0] f;
        f = {hi, lo};
        return (sel == SEL_HIGH) ? {1'b0, hi} :
               (sel == SEL_LOW)  ? {1'b0, lo} : f;
    endfunction

    // Fields are appended at the LSB end, so the oldest field is sent
    // first when the shifter walks from bit txLen-1 down to bit 0.
    function automatic frame_type build_frame(input ref_state_type s);
        frame_type         f;
        logic [DATA_W-1:0] d;
        logic [1:0]        fl;
        logic              cp;
        logic              fp;
        f  = '0;
        fl = '0;
        // real result unless a pattern is chosen
        d = s.convLatch;
        if (s.dataPatternSel == PAT_ZEROS)
            d = '0;
        else if (s.dataPatternSel == PAT_ONES)
            d = '1;
        else if (s.dataPatternSel == PAT_ALT1)
            d = altSingle;
        else if (s.dataPatternSel == PAT_ALT2)
            d = altPair;
        f.word = MAX_W'(d);
        f.len  = LEN_W'(DATA_W);
        if (s.includeUnitId)
        begin
            f.word = {f.word[MAX_W-UNIT_ID_BITS-1:0], unitId};
            f.len  = f.len + LEN_W'(UNIT_ID_BITS);
        end
        fl = sel_flags(s.supplyAlarmInsertSel, supplyAlarmHigh,
                       supplyAlarmLow);
        if (s.supplyAlarmInsertSel == SEL_BOTH)
        begin
            f.word = {f.word[MAX_W-3:0], fl};
            f.len  = f.len + LEN_W'(2);
        end
        else if (s.supplyAlarmInsertSel != SEL_RESET)
        begin
            f.word = {f.word[MAX_W-2:0], fl[0]};
            f.len  = f.len + LEN_W'(1);
        end
        fl = sel_flags(s.inputAlarmInsertSel, inputAlarmHigh,
                       inputAlarmLow);
        if (s.inputAlarmInsertSel == SEL_BOTH)
        begin
            f.word = {f.word[MAX_W-3:0], fl};
            f.len  = f.len + LEN_W'(2);
        end
        else if (s.inputAlarmInsertSel != SEL_RESET)
        begin
            f.word = {f.word[MAX_W-2:0], fl[0]};
            f.len  = f.len + LEN_W'(1);
        end
        if (s.includeSpanCode)
        begin
            f.word = {f.word[MAX_W-SPAN_BITS-1:0], s.span};
            f.len  = f.len + LEN_W'(SPAN_BITS);
        end
        cp = ^d;
        // frame parity over everything sent before the parity bits
        fp = ^f.word;
        if (s.parityAppendOn)
        begin
            f.word = {f.word[MAX_W-PARITY_BITS-1:0], cp, fp};
            f.len  = f.len + LEN_W'(PARITY_BITS);
        end
        return f;
    endfunction

    // ------------------------------------------------------------------
    // Register bus and frame assembly
    // ------------------------------------------------------------------
    logic        accessDone;
    logic        hitCtrl;
    logic        hitRange;
    logic [31:0] ctrlView;
    logic [31:0] rangeView;
    frame_type   frame;

    always_comb
    begin
        next_r     = r;
        frame      = build_frame(r);
        hitCtrl    = paddr == CTRL_OFFSET;
        hitRange   = paddr == RANGE_OFFSET;
        accessDone = psel && penable && r.ready;
        ctrlView = '0;
        ctrlView[UNIT_ID_BIT]                       = r.includeUnitId;
        ctrlView[SUPPLY_SEL_LSB+1:SUPPLY_SEL_LSB]   = r.supplyAlarmInsertSel;
        ctrlView[INPUT_SEL_LSB+1:INPUT_SEL_LSB]     = r.inputAlarmInsertSel;
        ctrlView[SPAN_INCL_BIT]                     = r.includeSpanCode;
        ctrlView[PARITY_BIT]                        = r.parityAppendOn;
        ctrlView[PATTERN_LSB+2:PATTERN_LSB]         = r.dataPatternSel;
        rangeView = '0;
        rangeView[REF_OFF_BIT]                      = r.refOff;
        rangeView[SPAN_CODE_LSB+SPAN_BITS-1:SPAN_CODE_LSB] = r.span;

        next_r.csMeta = frameSelectN;
        next_r.csSync = r.csMeta;
        if (convValid)
            next_r.convLatch = convData;

        // Two-cycle access: pready rises in the second access cycle and
        // the transfer completes at the next edge.
        next_r.ready = 1'b0;
        if (psel && penable && !r.ready)
        begin
            next_r.ready  = 1'b1;
            next_r.slvErr = !(hitCtrl || hitRange);
            next_r.rdata  = pwrite ? 32'h0000_0000 :
                            hitCtrl ? ctrlView :
                            hitRange ? rangeView : 32'h0000_0000;
        end
        if (accessDone && pwrite && hitCtrl && pstrb[1])
        begin
            next_r.includeUnitId        = pwdata[UNIT_ID_BIT];
            next_r.supplyAlarmInsertSel =
                pwdata[SUPPLY_SEL_LSB+1:SUPPLY_SEL_LSB];
            next_r.inputAlarmInsertSel  =
                pwdata[INPUT_SEL_LSB+1:INPUT_SEL_LSB];
            next_r.includeSpanCode      = pwdata[SPAN_INCL_BIT];
        end
        if (accessDone && pwrite && hitCtrl && pstrb[0])
        begin
            next_r.parityAppendOn = pwdata[PARITY_BIT];
            next_r.dataPatternSel = pwdata[PATTERN_LSB+2:PATTERN_LSB];
        end
        if (accessDone && pwrite && hitRange && pstrb[0])
        begin
            next_r.refOff = pwdata[REF_OFF_BIT];
            next_r.span   = pwdata[SPAN_CODE_LSB+SPAN_BITS-1:SPAN_CODE_LSB];
        end
        // application reset spares parity enable and span code
        if (appResetReq)
        begin
            next_r.includeUnitId        = FLAG_RESET;
            next_r.supplyAlarmInsertSel = SEL_RESET;
            next_r.inputAlarmInsertSel  = SEL_RESET;
            next_r.includeSpanCode      = FLAG_RESET;
            next_r.dataPatternSel       = PATTERN_RESET;
            next_r.refOff               = FLAG_RESET;
        end
        next_r.spanLegal = span_legal(r.span);
        // The shifter reads txWord without a crossing of its own; it is
        // only refreshed while no frame is selected, so it is static
        // whenever the serial clock runs.
        if (r.csSync)
        begin
            next_r.txWord = frame.word;
            next_r.txLen  = frame.len;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r                      <= '0;
            r.csMeta               <= 1'b1;
            r.csSync               <= 1'b1;
            r.dataPatternSel       <= PATTERN_RESET;
            r.span                 <= SPAN_CODE_RESET;
            r.spanLegal            <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign prdata        = r.rdata;
    assign pready        = r.ready;
    assign pslverr       = r.slvErr;
    // reference control straight from the register bit
    assign onchipRefOff  = r.refOff;
    assign spanCode      = r.span;
    assign spanCodeLegal = r.spanLegal;

    // ------------------------------------------------------------------
    // Serial shifter on the host's clock
    // ------------------------------------------------------------------
    // The frame's own select clears the shifter, so nothing depends on
    // serial clock edges outside a frame.
    logic linkRst_n;
    assign linkRst_n = rst_n && !frameSelectN;

    always_comb
    begin
        next_l = l;
        // the shifter sends txLen bits, parity included
        if (l.bitIdx < r.txLen)
        begin
            next_l.serialOut = r.txWord[LEN_W'(r.txLen - l.bitIdx - 1'b1)];
            next_l.bitIdx    = l.bitIdx + 1'b1;
        end
        else
            next_l.serialOut = 1'b0;
    end

    always_ff @(posedge serialClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
            l <= '0;
        else
            l <= next_l;
    end

    assign serialOutLines = l.serialOut;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic onlyData;
    assign onlyData = !r.includeUnitId && !r.includeSpanCode
                   && r.supplyAlarmInsertSel == SEL_RESET
                   && r.inputAlarmInsertSel == SEL_RESET;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_apbWrite(logic [11:0] a);
        psel && penable && pready && pwrite && paddr == a && pstrb[0];
    endsequence
    sequence s_apbReadDone(logic [11:0] a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence

    a_rsvd_read_zero: assert property (
        s_apbReadDone(CTRL_OFFSET) |-> (prdata & ~CTRL_RW_MASK) == 0)
        else $error("reserved control bits read nonzero");
    a_range_write_back: assert property (
        s_apbWrite(RANGE_OFFSET) ##0 !appResetReq |=>
        spanCode == $past(pwdata[3:0]) && onchipRefOff == $past(pwdata[6]))
        else $error("range register write not stored");
    a_unit_id_slot: assert property (
        r.csSync && r.includeUnitId && !r.includeSpanCode
        && r.supplyAlarmInsertSel == 0 && r.inputAlarmInsertSel == 0
        && !r.parityAppendOn |=> r.txWord[3:0] == $past(unitId)
        && r.txLen == LEN_W'(DATA_W + 4))
        else $error("unit id missing from frame");
    a_supply_both: assert property (
        r.csSync && r.supplyAlarmInsertSel == SEL_BOTH && !r.parityAppendOn
        && !r.includeSpanCode && r.inputAlarmInsertSel == 0 |=>
        r.txWord[1:0] == {$past(supplyAlarmHigh), $past(supplyAlarmLow)})
        else $error("supply alarm flags wrong");
    a_input_high: assert property (
        r.csSync && r.inputAlarmInsertSel == SEL_HIGH && !r.parityAppendOn
        && !r.includeSpanCode |=> r.txWord[0] == $past(inputAlarmHigh))
        else $error("input alarm high flag wrong");
    a_span_order: assert property (
        r.csSync && r.includeUnitId && r.includeSpanCode
        && r.supplyAlarmInsertSel == 0 && r.inputAlarmInsertSel == 0
        && !r.parityAppendOn |=>
        r.txWord[7:0] == {$past(unitId), $past(r.span)})
        else $error("unit id and span code out of order");
    a_frame_parity: assert property (
        r.csSync && r.parityAppendOn |=>
        (^(r.txWord & ~MAX_W'(2))) == 1'b0)
        else $error("frame parity not even");
    a_data_parity: assert property (
        r.csSync && r.parityAppendOn && onlyData |=>
        r.txWord[1] == ^r.txWord[DATA_W+1:2]
        && r.txLen == LEN_W'(DATA_W + 2))
        else $error("result parity wrong");
    a_real_data: assert property (
        r.csSync && !r.dataPatternSel[2] && onlyData && !r.parityAppendOn
        |=> r.txWord == MAX_W'($past(r.convLatch)))
        else $error("conversion data not sent");
    a_zero_pattern: assert property (
        r.csSync && r.dataPatternSel == PAT_ZEROS && onlyData
        && !r.parityAppendOn |=> r.txWord == '0)
        else $error("all zero pattern wrong");
    a_pair_pattern: assert property (
        r.csSync && r.dataPatternSel == PAT_ALT2 && onlyData
        && !r.parityAppendOn |=> r.txWord[DATA_W-1 -: 4] == 4'h3)
        else $error("pair pattern wrong");
    a_app_keeps: assert property (
        appResetReq |=> r.parityAppendOn == $past(r.parityAppendOn)
        && spanCode == $past(spanCode) && r.dataPatternSel == 0)
        else $error("application reset handling wrong");

endmodule

/* File: core/frame_composer_pkg.sv */
// Constants shared by the output frame composer: register map, field
// positions, reset values, test pattern codes and frame field widths.
// Assumes a 32-bit APB register bus with byte addresses.
package frame_composer_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          APB_ADDR_BITS  = 12;
    localparam logic [11:0] CTRL_OFFSET    = 12'h010;
    localparam logic [11:0] RANGE_OFFSET   = 12'h014;
    localparam logic [31:0] CTRL_RW_MASK   = 32'h0000_7D0F;
    localparam logic [31:0] RANGE_RW_MASK  = 32'h0000_004F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int UNIT_ID_BIT     = 14;
    localparam int SUPPLY_SEL_LSB  = 12;
    localparam int INPUT_SEL_LSB   = 10;
    localparam int SPAN_INCL_BIT   = 8;
    localparam int PARITY_BIT      = 3;
    localparam int PATTERN_LSB     = 0;
    localparam int REF_OFF_BIT     = 6;
    localparam int SPAN_CODE_LSB   = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] PATTERN_RESET   = 3'h0;
    localparam logic [1:0] SEL_RESET       = 2'h0;
    localparam logic [3:0] SPAN_CODE_RESET = 4'h0;
    localparam logic       FLAG_RESET      = 1'b0;

    // ------------------------------------------------------------------
    // Field codes and frame widths
    // ------------------------------------------------------------------
    localparam logic [2:0] PAT_ZEROS = 3'h4;
    localparam logic [2:0] PAT_ONES  = 3'h5;
    localparam logic [2:0] PAT_ALT1  = 3'h6;
    localparam logic [2:0] PAT_ALT2  = 3'h7;
    localparam logic [1:0] SEL_HIGH  = 2'h1;
    localparam logic [1:0] SEL_LOW   = 2'h2;
    localparam logic [1:0] SEL_BOTH  = 2'h3;
    localparam int CONV_BITS    = 12;
    localparam int UNIT_ID_BITS = 4;
    localparam int SPAN_BITS    = 4;
    localparam int PARITY_BITS  = 2;

    typedef enum logic [3:0] {
        SPAN_BI_3_00 = 4'h0,
        SPAN_BI_2_50 = 4'h1,
        SPAN_BI_1_50 = 4'h2,
        SPAN_BI_1_25 = 4'h3,
        SPAN_BI_0_625 = 4'h4,
        SPAN_UNI_3_00 = 4'h8,
        SPAN_UNI_2_50 = 4'h9,
        SPAN_UNI_1_50 = 4'hA,
        SPAN_UNI_1_25 = 4'hB
    } span_code_type;

endpackage

/* File: dv/host_reader.sv */
// Host side of the serial link: frames the link and captures the bits.
// Assumes the composer shifts MSB first and idles its line low.
`timescale 1ns/1ps
module host_reader (
    // Serial link
    output logic      serialClk,
    output logic      frameSelectN,
    input  wire logic serialOutLines
);
    initial
    begin
        serialClk    = 1'b0;
        frameSelectN = 1'b1;
    end

    // The clock only runs inside a frame; extra bits show the idle level.
    // host clocks parity bits
    task automatic readFrame(input int nBits, output logic [63:0] got);
        got          = '0;
        frameSelectN = 1'b0;
        #40;
        repeat (nBits)
        begin
            #62.5 serialClk = 1'b1;
            #62.5 got = {got[62:0], serialOutLines};
            serialClk = 1'b0;
        end
        #62.5 frameSelectN = 1'b1;
        #40;
    endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench of the output frame composer.
// Assumes the APB slave answers in its own time and the host model frames.
`timescale 1ns/1ps
module tb;
    import frame_composer_pkg::*;
    typedef struct packed {logic [15:0] ctrl; logic [7:0] span;} row_type;
    logic        ref_clk = 0, rst_n = 0, appResetReq = 0, convValid = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0, convData = '0, cd;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0]  unitId = '0, alarm = '0, spanCode, id, strb = 4'hF;
    logic        pready, pslverr, onchipRefOff, spanCodeLegal, e;
    logic        serialClk, frameSelectN, serialOutLines;
    logic [63:0] ev, got;
    int          errTotal = 0, totalChecks = 0, cycles = 0, n;
    row_type     rows [15] = '{'{16'h0000, 8'h00}, '{16'h000B, 8'h01},
        '{16'h0004, 8'h02}, '{16'h4105, 8'h03}, '{16'h0006, 8'h04},
        '{16'h0007, 8'h08}, '{16'h4000, 8'h09}, '{16'h1000, 8'h0A},
        '{16'h2000, 8'h0B}, '{16'h3000, 8'h40}, '{16'h0400, 8'h41},
        '{16'h0800, 8'h44}, '{16'h0D08, 8'h4B}, '{16'h7D0E, 8'h48},
        '{16'h7D09, 8'h43}};

    always #4 ref_clk = ~ref_clk;

    adc_output_frame_composer u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .appResetReq(appResetReq), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convData(convData), .convValid(convValid), .unitId(unitId),
        .supplyAlarmHigh(alarm[3]), .supplyAlarmLow(alarm[2]),
        .inputAlarmHigh(alarm[1]), .inputAlarmLow(alarm[0]),
        .onchipRefOff(onchipRefOff), .spanCode(spanCode),
        .spanCodeLegal(spanCodeLegal), .serialClk(serialClk),
        .frameSelectN(frameSelectN), .serialOutLines(serialOutLines));
    host_reader u_host (.serialClk(serialClk), .frameSelectN(frameSelectN),
        .serialOutLines(serialOutLines));

    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        totalChecks++;
        if (g !== x)
        begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // Request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected frame: data, id, supply flags, input flags, span, parity.
    function automatic int build(input logic [15:0] c, input logic [3:0] sp,
        input logic [11:0] dv, input logic [3:0] uid, input logic [3:0] al,
        output logic [63:0] v);
        logic [11:0] d;
        int          k;
        case (c[2:0])
            PAT_ZEROS: d = 12'h000;
            PAT_ONES:  d = 12'hFFF;
            PAT_ALT1:  d = 12'h555;
            PAT_ALT2:  d = 12'h333;
            default:   d = dv;
        endcase
        v = 64'(d);
        k = 12;
        if (c[14]) begin v = {v[59:0], uid}; k += 4; end
        if (c[13] & c[12]) begin v = {v[61:0], al[3:2]}; k += 2; end
        else if (c[13] | c[12]) begin v = {v[62:0], al[{1'b1, c[12]}]}; k++; end
        if (c[11] & c[10]) begin v = {v[61:0], al[1:0]}; k += 2; end
        else if (c[11] | c[10]) begin v = {v[62:0], al[{1'b0, c[10]}]}; k++; end
        if (c[8]) begin v = {v[59:0], sp}; k += 4; end
        if (c[3]) begin v = {v[61:0], ^d, ^v}; k += 2; end
        return k;
    endfunction

    task automatic giveVerdict;
        $display("checks %0d, mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000) begin errTotal++; giveVerdict(); end
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            cd = CONV_BITS'(12'hA5C + i);
            id = ~4'(i);
            @(posedge ref_clk);
            convData  <= cd;
            unitId    <= id;
            alarm     <= 4'(i * 5);
            convValid <= 1'b1;
            @(posedge ref_clk);
            convValid <= 1'b0;
            apb(1, CTRL_OFFSET, 32'(rows[i].ctrl) | ~CTRL_RW_MASK, r, e);
            apb(1, RANGE_OFFSET, 32'(rows[i].span) | ~RANGE_RW_MASK, r, e);
            apb(0, CTRL_OFFSET, '0, r, e);
            chk(r, 32'(rows[i].ctrl));
            apb(0, RANGE_OFFSET, '0, r, e);
            chk(r, 32'(rows[i].span));
            chk({onchipRefOff, spanCode}, {rows[i].span[6], rows[i].span[3:0]});
            n = build(rows[i].ctrl, rows[i].span[3:0], cd, id, 4'(i * 5), ev);
            u_host.readFrame(n + 2, got);
            chk(got, ev << 2);
        end
        apb(1, CTRL_OFFSET, 32'h0000_7D0D, r, e);
        apb(1, RANGE_OFFSET, 32'h0000_004B, r, e);
        @(posedge ref_clk);
        appResetReq <= 1'b1;
        @(posedge ref_clk);
        appResetReq <= 1'b0;
        apb(0, CTRL_OFFSET, '0, r, e);
        chk(r, 32'h0000_0008);
        apb(0, RANGE_OFFSET, '0, r, e);
        chk(r, 32'h0000_000B);
        strb <= 4'h2;
        apb(1, CTRL_OFFSET, 32'h0000_4005, r, e);
        strb <= 4'hF;
        apb(0, CTRL_OFFSET, '0, r, e);
        chk(r, 32'h0000_4008);
        apb(1, RANGE_OFFSET, 32'h0000_0005, r, e);
        repeat (3) @(posedge ref_clk);
        chk(spanCodeLegal, 1'b0);
        apb(1, RANGE_OFFSET, 32'h0000_0004, r, e);
        repeat (3) @(posedge ref_clk);
        chk(spanCodeLegal, 1'b1);
        apb(1, 12'h018, 32'hFFFF_FFFF, r, e);
        apb(0, 12'h018, '0, r, e);
        chk({e, r}, {1'b1, 32'h0000_0000});
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(0, RANGE_OFFSET, '0, r, e);
        chk(r, 32'h0000_0000);
        chk(serialOutLines, 1'b0);
        giveVerdict();
    end
endmodule
